// file: rtl/gpp_pkg.sv
package gpp_pkg;

	// ==========================================================
	// Register map (printed offsets are not word aligned: index)
	localparam logic [3:0] GPP_IDX_DATA_A   = 4'h0;
	localparam logic [3:0] GPP_IDX_DATA_B   = 4'h1;
	localparam logic [3:0] GPP_IDX_DATA_C   = 4'h2;
	localparam logic [3:0] GPP_IDX_DIR_A    = 4'h4;
	localparam logic [3:0] GPP_IDX_DIR_B    = 4'h5;
	localparam logic [3:0] GPP_IDX_DIR_C    = 4'h6;
	localparam logic [3:0] GPP_IDX_PULL_AB  = 4'h8;
	localparam logic [3:0] GPP_IDX_PULL_C   = 4'h9;
	localparam logic [3:0] GPP_IDX_OD_SEL   = 4'hA;
	localparam logic [3:0] GPP_IDX_IRQ_CTL  = 4'hB;

	// ==========================================================
	// Field positions
	localparam int GPP_POS_PULL_AL  = 0;
	localparam int GPP_POS_PULL_AH  = 1;
	localparam int GPP_POS_PULL_BL  = 2;
	localparam int GPP_POS_PULL_BH  = 3;
	localparam int GPP_POS_PULL_C   = 0;
	localparam int GPP_POS_OD_C     = 2;
	localparam int GPP_POS_IRQ_EN   = 0;
	localparam int GPP_POS_C3       = 3;

	// ==========================================================
	// Reset values and masks
	localparam logic [7:0] GPP_RST_BYTE  = 8'h00;
	localparam logic [3:0] GPP_RST_NIB   = 4'h0;
	localparam logic [7:0] GPP_MASK_C    = 8'h0F;
	localparam logic [3:0] GPP_C_OD_ONLY = 4'hC;
	localparam logic [3:0] GPP_SYNC_RST  = 4'h0;

	typedef enum logic [1:0] {
		GPP_BUS_IDLE  = 2'b00,
		GPP_BUS_WRITE = 2'b01,
		GPP_BUS_READ  = 2'b11
	} gpp_phase_e;

	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
		logic [3:0] c;
	} gpp_pins_s;

endpackage

// file: rtl/gpp_sync.sv
`timescale 1ns/1ps
// ==========================================================
// Three-stage pin synchroniser; change accepted when stages 2,3 agree
module gpp_sync
	import gpp_pkg::*;
#(
	parameter int W = 4
) (
	input  wire logic         hclk,     // Clock
	input  wire logic         hresetn,  // Async reset, low
	input  wire logic [W-1:0] d,        // Raw pin levels
	output logic      [W-1:0] q         // Filtered levels
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} gpp_sync_s;

	gpp_sync_s st_r;
	gpp_sync_s st_nxt;

	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int i = 0; i < W; i++) begin
			if (st_r.s2[i] == st_r.s3[i]) begin
				st_nxt.q[i] = st_r.s3[i];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.q;
endmodule // gpp_sync

// file: rtl/gpp_port.sv
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module gpp_port
	import gpp_pkg::*;
(
	input  wire logic        hclk,        // Bus clock
	input  wire logic        hresetn,     // Async reset, low
	input  wire logic        hsel,        // Slave select
	input  wire logic [31:0] haddr,       // Address
	input  wire logic [1:0]  htrans,      // Transfer type
	input  wire logic        hwrite,      // Write
	input  wire logic [2:0]  hsize,       // Size
	input  wire logic        hready,      // Bus ready
	input  wire logic [31:0] hwdata,      // Write data
	output logic      [31:0] hrdata,      // Read data
	output logic             hreadyout,   // Slave ready
	output logic             hresp,       // Response
	input  wire gpp_pins_s   pin_in,      // Pin levels
	output gpp_pins_s        pin_out,     // Pin drive values
	output gpp_pins_s        pin_oe_n,    // Drive enable, low drives
	output gpp_pins_s        pin_pullup,  // Pull-up connect
	output logic             ext_irq_in   // External interrupt input
);
	// ==========================================================
	// State
	typedef struct packed {
		// Bus phase tracking
		gpp_phase_e phase;
		logic [3:0] idx;

		// Port data latches
		logic [7:0] lat_a;
		logic [7:0] lat_b;
		logic [3:0] lat_c;

		// Direction bits, one is output
		logic [7:0] dir_a;
		logic [7:0] dir_b;
		logic [3:0] dir_c;

		// Control bits
		logic [3:0] pull_ab;
		logic       pull_c;
		logic       od_c;
		logic       irq_en;

		// Registered outputs
		logic [31:0] rdata;
		gpp_pins_s  out;
		gpp_pins_s  oe_n;
		gpp_pins_s  pull;
		logic       irq;
	} gpp_port_s;

	gpp_port_s st_r;
	gpp_port_s st_nxt;
	gpp_pins_s pin_sync;

	// ==========================================================
	// Pin synchroniser
	gpp_sync #(
		.W ($bits(gpp_pins_s))
	) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.d       (pin_in),
		.q       (pin_sync)
	);

	// ==========================================================
	// Combinational helpers
	logic [7:0]  rd_a;      // Port A read value
	logic [7:0]  rd_b;      // Port B read value
	logic [3:0]  rd_c;      // Port C read value
	logic [3:0]  od_mask;   // Port C bits driving open-drain
	logic [7:0]  pull_a;    // Port A pull-up request per pin
	logic [7:0]  pull_b;    // Port B pull-up request per pin
	logic [7:0]  wb;        // Write byte
	logic        acc_take;  // Address phase accepted
	logic [11:0] wr_hit;    // One-hot data phase write target
	logic [7:0]  rd_byte;   // Byte of the addressed register

	// ==========================================================
	// Read values and pull-up requests
	always_comb begin
		// Output bits read the latch, input bits read the pin
		rd_a = (st_r.dir_a & st_r.lat_a) | (~st_r.dir_a & pin_sync.a);
		rd_b = (st_r.dir_b & st_r.lat_b) | (~st_r.dir_b & pin_sync.b);
		rd_c = (st_r.dir_c & st_r.lat_c) | (~st_r.dir_c & pin_sync.c);
		// C2, C3 never drive high; the select widens this to C0, C1
		od_mask = st_r.od_c ? 4'hF : GPP_C_OD_ONLY;
		pull_a = {{4{st_r.pull_ab[GPP_POS_PULL_AH]}}, {4{st_r.pull_ab[GPP_POS_PULL_AL]}}};
		// Port B requests exist, but the display drive keeps them off
		pull_b = {{4{st_r.pull_ab[GPP_POS_PULL_BH]}}, {4{st_r.pull_ab[GPP_POS_PULL_BL]}}};
		wb = hwdata[7:0];
		acc_take = hsel && hready && htrans[1];
	end

	// ==========================================================
	// Data phase write decode
	always_comb begin
		wr_hit = 12'h000;
		if (st_r.phase == GPP_BUS_WRITE) begin
			unique case (st_r.idx)
				// Data latches
				GPP_IDX_DATA_A: begin
					wr_hit[GPP_IDX_DATA_A] = 1'b1;
				end
				GPP_IDX_DATA_B: begin
					wr_hit[GPP_IDX_DATA_B] = 1'b1;
				end
				GPP_IDX_DATA_C: begin
					wr_hit[GPP_IDX_DATA_C] = 1'b1;
				end
				// Direction
				GPP_IDX_DIR_A: begin
					wr_hit[GPP_IDX_DIR_A] = 1'b1;
				end
				GPP_IDX_DIR_B: begin
					wr_hit[GPP_IDX_DIR_B] = 1'b1;
				end
				GPP_IDX_DIR_C: begin
					wr_hit[GPP_IDX_DIR_C] = 1'b1;
				end
				// Controls
				GPP_IDX_PULL_AB: begin
					wr_hit[GPP_IDX_PULL_AB] = 1'b1;
				end
				GPP_IDX_PULL_C: begin
					wr_hit[GPP_IDX_PULL_C] = 1'b1;
				end
				GPP_IDX_OD_SEL: begin
					wr_hit[GPP_IDX_OD_SEL] = 1'b1;
				end
				GPP_IDX_IRQ_CTL: begin
					wr_hit[GPP_IDX_IRQ_CTL] = 1'b1;
				end
				default: begin
					wr_hit = 12'h000;
				end
			endcase
		end
	end

	// ==========================================================
	// Read mux; unmapped indices and reserved bits read zero
	always_comb begin
		rd_byte = 8'h00;
		unique case (haddr[5:2])
			// Data latches or pins
			GPP_IDX_DATA_A: begin
				rd_byte = rd_a;
			end
			GPP_IDX_DATA_B: begin
				rd_byte = rd_b;
			end
			GPP_IDX_DATA_C: begin
				rd_byte[3:0] = rd_c;
			end
			// Direction
			GPP_IDX_DIR_A: begin
				rd_byte = st_r.dir_a;
			end
			GPP_IDX_DIR_B: begin
				rd_byte = st_r.dir_b;
			end
			GPP_IDX_DIR_C: begin
				rd_byte[3:0] = st_r.dir_c;
			end
			// Controls
			GPP_IDX_PULL_AB: begin
				rd_byte[3:0] = st_r.pull_ab;
			end
			GPP_IDX_PULL_C: begin
				rd_byte[GPP_POS_PULL_C] = st_r.pull_c;
			end
			GPP_IDX_OD_SEL: begin
				rd_byte[GPP_POS_OD_C] = st_r.od_c;
			end
			GPP_IDX_IRQ_CTL: begin
				rd_byte[GPP_POS_IRQ_EN] = st_r.irq_en;
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
	end

	// ==========================================================
	// Next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata = 32'h0000_0000;
		// Writes land at the end of the data phase, no wait states
		if (wr_hit[GPP_IDX_DATA_A]) begin
			st_nxt.lat_a = wb;
		end
		if (wr_hit[GPP_IDX_DATA_B]) begin
			st_nxt.lat_b = wb;
		end
		if (wr_hit[GPP_IDX_DATA_C]) begin
			st_nxt.lat_c = wb[3:0];
		end
		// Direction bits
		if (wr_hit[GPP_IDX_DIR_A]) begin
			st_nxt.dir_a = wb;
		end
		if (wr_hit[GPP_IDX_DIR_B]) begin
			st_nxt.dir_b = wb;
		end
		if (wr_hit[GPP_IDX_DIR_C]) begin
			st_nxt.dir_c = wb[3:0];
		end
		// Control bits; reserved bits are not stored
		if (wr_hit[GPP_IDX_PULL_AB]) begin
			st_nxt.pull_ab = wb[3:0];
		end
		if (wr_hit[GPP_IDX_PULL_C]) begin
			st_nxt.pull_c = wb[GPP_POS_PULL_C];
		end
		if (wr_hit[GPP_IDX_OD_SEL]) begin
			st_nxt.od_c = wb[GPP_POS_OD_C];
		end
		if (wr_hit[GPP_IDX_IRQ_CTL]) begin
			st_nxt.irq_en = wb[GPP_POS_IRQ_EN];
		end

		// Address phase: capture target and read data together
		st_nxt.phase = GPP_BUS_IDLE;
		if (acc_take) begin
			st_nxt.idx = haddr[5:2];
			if (hwrite) begin
				st_nxt.phase = GPP_BUS_WRITE;
			end else begin
				st_nxt.phase = GPP_BUS_READ;
				st_nxt.rdata = {24'h00_0000, rd_byte};
			end
		end

		// ==========================================================
		// Port A: push-pull, pull-up only while an input
		for (int i = 0; i < 8; i++) begin
			st_nxt.out.a[i] = st_nxt.lat_a[i];
			st_nxt.oe_n.a[i] = ~st_nxt.dir_a[i];
			st_nxt.pull.a[i] = pull_a[i] & ~st_nxt.dir_a[i];
		end

		// ==========================================================
		// Port B: always driven by the display or by software
		for (int i = 0; i < 8; i++) begin
			// Display drivers hold the pin high until software takes it
			st_nxt.out.b[i] = st_nxt.dir_b[i] ? st_nxt.lat_b[i] : 1'b1;
			st_nxt.oe_n.b[i] = 1'b0;
			st_nxt.pull.b[i] = pull_b[i] & st_nxt.oe_n.b[i];
		end

		// ==========================================================
		// Port C: open-drain bits drive only a low, never a high
		for (int i = 0; i < 4; i++) begin
			if (st_nxt.dir_c[i] && od_mask[i]) begin
				st_nxt.out.c[i] = 1'b0;
				st_nxt.oe_n.c[i] = st_nxt.lat_c[i];
				st_nxt.pull.c[i] = st_nxt.pull_c & st_nxt.lat_c[i];
			end else begin
				// Open-drain bits show no high even while undriven
				st_nxt.out.c[i] = st_nxt.lat_c[i] & ~od_mask[i];
				st_nxt.oe_n.c[i] = ~st_nxt.dir_c[i];
				st_nxt.pull.c[i] = st_nxt.pull_c & ~st_nxt.dir_c[i];
			end
		end

		// ==========================================================
		// Sensed level, so C3 feeds the interrupt as input or open-drain
		if (st_nxt.irq_en) begin
			st_nxt.irq = pin_sync.c[GPP_POS_C3];
		end else begin
			st_nxt.irq = 1'b0;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// Bus
			st_r.phase   <= GPP_BUS_IDLE;
			st_r.idx     <= GPP_RST_NIB;
			st_r.rdata   <= 32'h0000_0000;
			// Latches and directions; every pin except the display port B starts as an input
			st_r.lat_a   <= GPP_RST_BYTE;
			st_r.lat_b   <= GPP_RST_BYTE;
			st_r.lat_c   <= GPP_RST_NIB;
			st_r.dir_a   <= GPP_RST_BYTE;
			st_r.dir_b   <= GPP_RST_BYTE;
			st_r.dir_c   <= GPP_RST_NIB;
			// Controls
			st_r.pull_ab <= GPP_RST_NIB;
			st_r.pull_c  <= 1'b0;
			st_r.od_c    <= 1'b0;
			st_r.irq_en  <= 1'b0;
			// Pin outputs: display port B drives high through reset
			st_r.out.a   <= GPP_RST_BYTE;
			st_r.out.b   <= 8'hFF;
			st_r.out.c   <= GPP_RST_NIB;
			st_r.oe_n.a  <= 8'hFF;
			st_r.oe_n.b  <= GPP_RST_BYTE;
			st_r.oe_n.c  <= 4'hF;
			st_r.pull.a  <= GPP_RST_BYTE;
			st_r.pull.b  <= GPP_RST_BYTE;
			st_r.pull.c  <= GPP_RST_NIB;
			st_r.irq     <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign hrdata     = st_r.rdata;
	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	assign pin_out    = st_r.out;
	assign pin_oe_n   = st_r.oe_n;
	assign pin_pullup = st_r.pull;
	assign ext_irq_in = st_r.irq;
endmodule // gpp_port

// file: dv/gpp_pin_model.sv
`timescale 1ns/1ps
// ==========================================================
// Pin load: drive wins, then outside source, then pull-up
module gpp_pin_model
	import gpp_pkg::*;
(
	input  wire logic hclk,       // Clock
	input  gpp_pins_s pin_out,    // Drive values
	input  gpp_pins_s pin_oe_n,   // Low drives
	input  gpp_pins_s pin_pullup, // Pull-up on
	input  gpp_pins_s ext_val,    // Outside level
	input  gpp_pins_s ext_en,     // Outside drives
	output gpp_pins_s pin_in      // Pin level
);
	logic [19:0] flt = 20'h0;
	// Floating pin wanders so no settled value can pass
	always @(posedge hclk) flt <= ~flt;
	assign pin_in = gpp_pins_s'((~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
		| (pin_oe_n & ~ext_en & (pin_pullup | flt)));
endmodule // gpp_pin_model

// file: dv/gpp_port_assertions.sv
`timescale 1ns/1ps
// ==========================================================
// Port checks
module gpp_port_assertions
	import gpp_pkg::*;
(
	input wire logic        hclk,       // Clock
	input wire logic        hresetn,    // Reset
	input wire logic        hsel,       // Select
	input wire logic [31:0] haddr,      // Address
	input wire logic [1:0]  htrans,     // Type
	input wire logic        hwrite,     // Write
	input wire logic        hready,     // Ready in
	input wire logic [31:0] hrdata,     // Read data
	input wire logic        hreadyout,  // Ready out
	input wire logic        hresp,      // Response
	input wire gpp_pins_s   pin_in,     // Pins
	input wire gpp_pins_s   pin_out,    // Drive
	input wire gpp_pins_s   pin_oe_n,   // Enable
	input wire gpp_pins_s   pin_pullup, // Pull-up
	input wire logic        ext_irq_in  // Irq
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic rd_q;
	assign rd_q = hsel && hready && htrans[1] && !hwrite;
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer");
	a_idle_zero: assert property (!rd_q |=> hrdata == 32'h0)
		else $error("idle read data");
	a_pull_ab_rd: assert property (rd_q && haddr == 32'h20 |=> hrdata[31:4] == 28'h0)
		else $error("pull ab high bits");
	a_pull_c_rd: assert property (rd_q && haddr == 32'h24 |=> hrdata[31:1] == 31'h0)
		else $error("pull c high bits");
	a_b_display: assert property (pin_oe_n.b == 8'h00 && pin_pullup.b == 8'h00)
		else $error("port b drive");
	a_c_no_high: assert property (pin_out.c[3:2] == 2'b00)
		else $error("c2 c3 drive high");
	a_pull_drv: assert property ((pin_pullup & ~pin_oe_n) == 20'h0)
		else $error("pull-up on driven pin");
	a_irq_quiet: assert property (!pin_in.c[3] [*8] |=> !ext_irq_in)
		else $error("irq with c3 low");
endmodule // gpp_port_assertions

// file: dv/testbench.sv
`timescale 1ns/1ps
// ==========================================================
// Port bench
module testbench;
	import gpp_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, rd_smp;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	gpp_pins_s   pin_in, pin_out, oe_n, pull, ext_val, ext_en;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	gpp_port dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(oe_n), .pin_pullup(pull), .ext_irq_in(irq));
	gpp_pin_model ext (.hclk(hclk), .pin_out(pin_out), .pin_oe_n(oe_n), .pin_pullup(pull),
		.ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
	task automatic give_verdict;
		if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [3:0] idx, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {26'h0, idx, 2'b00};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask
	// Read data held as it stood at the edge that closes the data phase
	always @(posedge hclk) rd_smp <= hrdata;
	task automatic rdc(input logic [3:0] idx, input logic [7:0] e);
		xfer(1'b0, idx, 8'h00);
		#1;
		chk(rd_smp, {24'h0, e});
	endtask
	// Ten cycles covers write commit plus the input filter
	task automatic pins(input logic [19:0] eo, input logic [19:0] ep);
		repeat (10) @(posedge hclk);
		chk({12'h0, oe_n}, {12'h0, eo});
		chk({12'h0, pull}, {12'h0, ep});
	endtask
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	initial begin
		repeat (3000) @(posedge hclk);
		n_mismatch++;
		give_verdict();
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		ext_val = 20'hC3000;
		ext_en = 20'hFF000;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		pins(20'hFF00F, 20'h0);
		chk({24'h0, pin_out.b}, 32'hFF);
		rdc(4'h4, 8'h00);
		rdc(4'h8, 8'h00);
		rdc(4'h9, 8'h00);
		rdc(4'h0, 8'hC3);
		xfer(1'b1, 4'h0, 8'h5A);
		xfer(1'b1, 4'h4, 8'h0F);
		rdc(4'h4, 8'h0F);
		rdc(4'h0, 8'hCA);
		xfer(1'b1, 4'h8, 8'hFF);
		rdc(4'h8, 8'h0F);
		pins(20'hF000F, 20'hF0000);
		xfer(1'b1, 4'h8, 8'h01);
		pins(20'hF000F, 20'h0);
		xfer(1'b1, 4'h4, 8'h00);
		pins(20'hFF00F, 20'h0F000);
		xfer(1'b1, 4'h0, 8'hF0);
		xfer(1'b1, 4'h4, 8'hFF);
		pins(20'h0000F, 20'h0);
		chk({24'h0, pin_out.a}, 32'hF0);
		xfer(1'b1, 4'h1, 8'h3C);
		xfer(1'b1, 4'h5, 8'hFF);
		pins(20'h0000F, 20'h0);
		chk({24'h0, pin_out.b}, 32'h3C);
		xfer(1'b1, 4'h9, 8'hFF);
		rdc(4'h9, 8'h01);
		xfer(1'b1, 4'h2, 8'h05);
		xfer(1'b1, 4'h6, 8'h0F);
		pins(20'h00004, 20'h00004);
		xfer(1'b1, 4'hA, 8'h04);
		pins(20'h00005, 20'h00005);
		chk({28'h0, pin_out.c}, 32'h0);
		rdc(4'h2, 8'h05);
		xfer(1'b1, 4'hB, 8'h01);
		pins(20'h00005, 20'h00005);
		chk({31'h0, irq}, 32'h0);
		xfer(1'b1, 4'h2, 8'h0D);
		pins(20'h0000D, 20'h0000D);
		chk({31'h0, irq}, 32'h1);
		xfer(1'b1, 4'h9, 8'h00);
		pins(20'h0000D, 20'h0);
		xfer(1'b1, 4'hB, 8'h00);
		pins(20'h0000D, 20'h0);
		chk({31'h0, irq}, 32'h0);
		xfer(1'b1, 4'h3, 8'hFF);
		rdc(4'h3, 8'h00);
		give_verdict();
	end
endmodule // testbench
bind gpp_port gpp_port_assertions chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out),
	.pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .ext_irq_in(ext_irq_in));
